// *** verilog/io_fwd_decoder.sv ***
// i/o forwarding decoder: claims primary i/o cycles and secondary upstream cycles
`timescale 1ns/1ns
`default_nettype none
`include "io_fwd_params.svh"

////////////////////////////////////////////////////////////////////////
module io_fwd_decoder
  import io_fwd_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // configuration byte access
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [7:0]  i_cfg_wdata,
  output logic      [7:0]  o_cfg_rdata,
  output logic             o_cfg_rvalid,
  // command and bridge control bits
  input  wire logic        i_io_en,
  input  wire logic        i_master_en,
  input  wire logic        i_isa_en,
  // primary address phase
  input  wire logic        i_pri_valid,
  input  wire logic        i_pri_is_io,
  input  wire logic [31:0] i_pri_addr,
  // primary decode answer
  output logic             o_pri_dec_valid,
  output logic             o_pri_claim,
  output logic      [31:0] o_pri_fwd_addr,
  // secondary address phase
  input  wire logic        i_sec_valid,
  input  wire logic        i_sec_is_io,
  input  wire logic [31:0] i_sec_addr,
  input  wire logic        i_sec_mem_up_hit,
  // secondary decode answer
  output logic             o_sec_dec_valid,
  output logic             o_sec_claim,
  output logic      [31:0] o_sec_fwd_addr,
  // route of the last answer, for both buses
  output var route_t       o_pri_route,
  output var route_t       o_sec_route
);

  io_window_t win;
  win_hit_t   pri_hit;
  win_hit_t   sec_hit;
  xact_t      pri_x;
  xact_t      sec_x;
  xact_t      pri_q;
  xact_t      sec_q;
  logic       pri_claim_q;
  logic       sec_claim_q;
  route_t     pri_route_q;
  route_t     sec_route_q;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers and window assembly
  io_cfg_regs u_regs (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr      (i_cfg_wr),
    .i_rd      (i_cfg_rd),
    .i_addr    (i_cfg_addr),
    .i_wdata   (i_cfg_wdata),
    .o_rdata   (o_cfg_rdata),
    .o_rvalid  (o_cfg_rvalid),
    .o_win     (win)
  );

  // one comparator per bus so both phases decode in the same cycle
  io_window_cmp u_pri_cmp (
    .i_win  (win),
    .i_addr (i_pri_addr),
    .o_hit  (pri_hit)
  );

  io_window_cmp u_sec_cmp (
    .i_win  (win),
    .i_addr (i_sec_addr),
    .o_hit  (sec_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode terms
  assign pri_x = '{valid: i_pri_valid, is_io: i_pri_is_io, addr: i_pri_addr};
  assign sec_x = '{valid: i_sec_valid, is_io: i_sec_is_io, addr: i_sec_addr};

  // isa carve-out applies only inside the window and below 64kb
  wire isa_pri_top = i_isa_en && pri_hit.in_win && pri_hit.low64k && pri_hit.isa_top;
  wire isa_sec_top = i_isa_en && sec_hit.in_win && sec_hit.low64k && sec_hit.isa_top;

  // downstream: io enable, inside window, not an isa top block
  wire pri_down = pri_x.valid && pri_x.is_io && i_io_en
                  && pri_hit.in_win && !isa_pri_top;

  // upstream i/o: outside the window, or the isa top 768 bytes
  wire sec_io_up  = sec_x.is_io && (!sec_hit.in_win || isa_sec_top);
  // memory ranges are decoded elsewhere; this block only gates them
  wire sec_mem_up = !sec_x.is_io && i_sec_mem_up_hit;
  wire sec_up     = sec_x.valid && i_master_en && (sec_io_up || sec_mem_up);

  ////////////////////////////////////////////////////////////////////////
  // primary answer register
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pri_q       <= '0;
      pri_claim_q <= 1'b0;
      pri_route_q <= ROUTE_NONE;
    end
    else
    begin
      pri_q       <= pri_x.valid ? pri_x : '{valid: 1'b0, is_io: pri_q.is_io, addr: pri_q.addr};
      pri_claim_q <= pri_down;
      pri_route_q <= pri_down ? ROUTE_DOWN : ROUTE_NONE;
    end
  end

  // secondary answer register
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sec_q       <= '0;
      sec_claim_q <= 1'b0;
      sec_route_q <= ROUTE_NONE;
    end
    else
    begin
      sec_q       <= sec_x.valid ? sec_x : '{valid: 1'b0, is_io: sec_q.is_io, addr: sec_q.addr};
      sec_claim_q <= sec_up;
      sec_route_q <= sec_up ? ROUTE_UP : ROUTE_NONE;
    end
  end

  // no translation: the captured address is the forwarded address
  assign o_pri_dec_valid = pri_q.valid;
  assign o_pri_claim     = pri_claim_q;
  assign o_pri_fwd_addr  = pri_q.addr;
  assign o_sec_dec_valid = sec_q.valid;
  assign o_sec_claim     = sec_claim_q;
  assign o_sec_fwd_addr  = sec_q.addr;
  assign o_pri_route     = pri_route_q;
  assign o_sec_route     = sec_route_q;

  ////////////////////////////////////////////////////////////////////////
  // checks; window changes mid-transaction are the caller's hazard
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  AST_PRI_IO_EN: assert property (
    i_pri_valid && !i_io_en |=> o_pri_dec_valid && !o_pri_claim
  ) else $error("primary cycle claimed with io enable clear");

  AST_SEC_MASTER: assert property (
    i_sec_valid && !i_master_en |=> o_sec_dec_valid && !o_sec_claim
  ) else $error("secondary cycle forwarded with master enable clear");

  AST_PRI_IN_WIN: assert property (
    o_pri_claim |-> $past(pri_hit.in_win) && $past(i_pri_is_io)
  ) else $error("primary claim outside the window");

  AST_SEC_OUTSIDE: assert property (
    i_sec_valid && i_sec_is_io && i_master_en && !sec_hit.in_win
    |=> o_sec_claim && o_sec_route == ROUTE_UP
  ) else $error("secondary io outside window not forwarded up");

  AST_WIN_OFF: assert property (
    i_pri_valid && (win.base > win.limit) |=> !o_pri_claim
  ) else $error("claim while the window is switched off");

  AST_WIN_OFF_UP: assert property (
    i_sec_valid && i_sec_is_io && i_master_en && (win.base > win.limit) |=> o_sec_claim
  ) else $error("secondary io not sent up while the window is off");

  AST_GRAN: assert property (
    win.base[11:0] == `IOF_BASE_FILL && win.limit[11:0] == `IOF_LIMIT_FILL
  ) else $error("window low bits not at 4kb granularity");

  AST_BASE_LO_RO: assert property (
    i_cfg_rd && i_cfg_addr == `IOF_OFF_BASE_LO
    |=> o_cfg_rvalid && o_cfg_rdata == {$past(win.base[15:12]), `IOF_RO_NIBBLE}
  ) else $error("base low byte reads wrong");

  AST_LIMIT_LO_RO: assert property (
    i_cfg_rd && i_cfg_addr == `IOF_OFF_LIMIT_LO
    |=> o_cfg_rvalid && o_cfg_rdata == {$past(win.limit[15:12]), `IOF_RO_NIBBLE}
  ) else $error("limit low byte reads wrong");

  AST_HI_WRITE: assert property (
    i_cfg_wr && i_cfg_addr == `IOF_OFF_LIMIT_HI |=> win.limit[23:16] == $past(i_cfg_wdata)
  ) else $error("limit upper word write not taken");

  AST_BASE_HI_WRITE: assert property (
    i_cfg_wr && i_cfg_addr == (`IOF_OFF_BASE_HI + 8'h01)
    |=> win.base[31:24] == $past(i_cfg_wdata)
  ) else $error("base upper word write not taken");

  AST_RESET_WIN: assert property (
    $past(i_sys_rst) |-> win.base == `IOF_RST_BASE && win.limit == `IOF_RST_LIMIT
  ) else $error("window not at reset value after reset");

  AST_ISA_DOWN_BLOCK: assert property (
    i_pri_valid && i_isa_en && pri_hit.low64k && pri_hit.isa_top |=> !o_pri_claim
  ) else $error("isa top block forwarded downstream");

  AST_ISA_UP: assert property (
    i_sec_valid && i_sec_is_io && i_isa_en && i_master_en
    && sec_hit.low64k && sec_hit.isa_top |=> o_sec_claim
  ) else $error("isa top block not forwarded upstream");

  AST_ISA_LOW_STAYS: assert property (
    i_sec_valid && i_sec_is_io && i_isa_en && sec_hit.in_win && !sec_hit.isa_top
    |=> !o_sec_claim
  ) else $error("isa low block inside window forwarded upstream");

  AST_HIGH_WIN: assert property (
    i_pri_valid && i_pri_is_io && i_io_en && pri_hit.in_win && !pri_hit.low64k
    |=> o_pri_claim
  ) else $error("address above 64kb in window not claimed");

  AST_ADDR_KEEP: assert property (
    o_pri_dec_valid |-> o_pri_fwd_addr == $past(i_pri_addr) && o_pri_route != ROUTE_UP
  ) else $error("primary address altered on forward");

  AST_SEC_ADDR_KEEP: assert property (
    o_sec_dec_valid |-> o_sec_fwd_addr == $past(i_sec_addr) && o_sec_route != ROUTE_DOWN
  ) else $error("secondary address altered on forward");

  AST_INCLUSIVE: assert property (
    i_pri_valid && i_pri_is_io && i_io_en && !i_isa_en && win.base <= win.limit
    && (i_pri_addr == win.base || i_pri_addr == win.limit) |=> o_pri_claim
  ) else $error("window edge address not claimed");

  // answers are one-cycle strobes that follow each phase
  AST_PRI_STROBE: assert property (
    i_pri_valid |=> o_pri_dec_valid
  ) else $error("primary phase gave no decode strobe");

  AST_SEC_STROBE: assert property (
    i_sec_valid |=> o_sec_dec_valid
  ) else $error("secondary phase gave no decode strobe");

  AST_PRI_STROBE_LEN: assert property (
    !i_pri_valid |=> !o_pri_dec_valid
  ) else $error("primary decode strobe without a phase");

  AST_SEC_STROBE_LEN: assert property (
    !i_sec_valid |=> !o_sec_dec_valid
  ) else $error("secondary decode strobe without a phase");

  AST_PRI_ROUTE_MATCH: assert property (
    o_pri_route == (o_pri_claim ? ROUTE_DOWN : ROUTE_NONE)
  ) else $error("primary route disagrees with claim");

  AST_SEC_ROUTE_MATCH: assert property (
    o_sec_route == (o_sec_claim ? ROUTE_UP : ROUTE_NONE)
  ) else $error("secondary route disagrees with claim");

  AST_PRI_CLAIM_STROBE: assert property (
    o_pri_claim |-> o_pri_dec_valid
  ) else $error("primary claim outside a decode strobe");

  AST_SEC_CLAIM_STROBE: assert property (
    o_sec_claim |-> o_sec_dec_valid
  ) else $error("secondary claim outside a decode strobe");

  // window and isa decode seen from both sides
  AST_PRI_NOT_IO: assert property (
    i_pri_valid && !i_pri_is_io |=> !o_pri_claim
  ) else $error("primary memory cycle claimed as io");

  AST_PRI_OUT_WIN: assert property (
    i_pri_valid && !pri_hit.in_win |=> !o_pri_claim
  ) else $error("primary io outside the window claimed");

  AST_SEC_IN_WIN: assert property (
    i_sec_valid && i_sec_is_io && !i_isa_en && sec_hit.in_win
    |=> !o_sec_claim
  ) else $error("secondary io inside the window sent up");

  AST_SEC_MEM_UP: assert property (
    i_sec_valid && !i_sec_is_io && i_master_en
    |=> o_sec_claim == $past(i_sec_mem_up_hit)
  ) else $error("secondary memory forward wrong");

  AST_ISA_LOW_DOWN: assert property (
    i_pri_valid && i_pri_is_io && i_io_en && i_isa_en && pri_hit.in_win
    && !pri_hit.isa_top |=> o_pri_claim
  ) else $error("isa bottom block not forwarded downstream");

  AST_ISA_SEC_HIGH: assert property (
    i_sec_valid && i_sec_is_io && sec_hit.in_win && !sec_hit.low64k
    |=> !o_sec_claim
  ) else $error("secondary io above 64kb in window sent up");

  // configuration writes land and nothing else moves the window
  AST_BASE_NIB_WRITE: assert property (
    i_cfg_wr && i_cfg_addr == `IOF_OFF_BASE_LO
    |=> win.base[15:12] == $past(i_cfg_wdata[7:4])
  ) else $error("base low byte write not taken");

  AST_LIMIT_NIB_WRITE: assert property (
    i_cfg_wr && i_cfg_addr == `IOF_OFF_LIMIT_LO
    |=> win.limit[15:12] == $past(i_cfg_wdata[7:4])
  ) else $error("limit low byte write not taken");

  AST_WIN_HOLD: assert property (
    !i_cfg_wr |=> $stable(win)
  ) else $error("window moved without a write");

  AST_RESET_OUT: assert property (
    $past(i_sys_rst)
    |-> !o_pri_dec_valid && !o_sec_dec_valid && !o_pri_claim && !o_sec_claim
  ) else $error("decode answer not idle after reset");

endmodule
`default_nettype wire

// *** verilog/io_fwd_params.svh ***
// constants for the i/o forwarding decoder: offsets, fields, reset values, timing
`ifndef IO_FWD_PARAMS_SVH
`define IO_FWD_PARAMS_SVH

// configuration byte offsets
`define IOF_OFF_BASE_LO   8'h1c
`define IOF_OFF_LIMIT_LO  8'h1d
`define IOF_OFF_BASE_HI   8'h30
`define IOF_OFF_LIMIT_HI  8'h32

// field layout and fixed values
`define IOF_RO_NIBBLE     4'h1
`define IOF_GRAN_BITS     12
`define IOF_BASE_FILL     12'h000
`define IOF_LIMIT_FILL    12'hfff
`define IOF_LOW64K_UPPER  16'h0000
`define IOF_ISA_SEL_MSB   9
`define IOF_ISA_SEL_LSB   8
`define IOF_ISA_LOW_BLK   2'h0

// reset values
`define IOF_RST_NIBBLE    4'h0
`define IOF_RST_UPPER     16'h0000
`define IOF_RST_BASE      32'h0000_0000
`define IOF_RST_LIMIT     32'h0000_0fff

// cycles from a sampled address phase to the decode answer
`define IOF_DEC_LAT       1

`endif

// *** verilog/io_fwd_pkg.sv ***
// types shared by the i/o forwarding decoder modules
`default_nettype none
package io_fwd_pkg;

  // assembled 32-bit window bounds
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
  } io_window_t;

  // one address phase seen on a bus
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [31:0] addr;
  } xact_t;

  // window comparison results for one address
  typedef struct packed {
    logic in_win;
    logic low64k;
    logic isa_top;
  } win_hit_t;

  // where a decoded transaction goes
  typedef enum logic [1:0] {
    ROUTE_NONE,
    ROUTE_DOWN,
    ROUTE_UP
  } route_t;

endpackage
`default_nettype wire

// *** verilog/io_window_cmp.sv ***
// compares one address against the i/o window and the isa sub-block layout
`timescale 1ns/1ns
`default_nettype none
`include "io_fwd_params.svh"
module io_window_cmp
  import io_fwd_pkg::*;
(
  // window and address
  input  wire io_window_t  i_win,
  input  wire logic [31:0] i_addr,
  // results
  output var win_hit_t     o_hit
);

  // inclusive at both ends; base above limit leaves no address inside
  wire inside_win = (i_addr >= i_win.base) && (i_addr <= i_win.limit);
  wire below_64k  = (i_addr[31:16] == `IOF_LOW64K_UPPER);
  // any of bits 9:8 set means the top 768 bytes of an aligned 1kb block
  wire top_block  = (i_addr[`IOF_ISA_SEL_MSB:`IOF_ISA_SEL_LSB] != `IOF_ISA_LOW_BLK);
  // one driver for the whole result struct
  assign o_hit = '{in_win: inside_win, low64k: below_64k, isa_top: top_block};

endmodule
`default_nettype wire

// *** verilog/io_cfg_regs.sv ***
// i/o base and limit configuration bytes with the assembled window
`timescale 1ns/1ns
`default_nettype none
`include "io_fwd_params.svh"
module io_cfg_regs
  import io_fwd_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // configuration byte access
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rvalid,
  // assembled window
  output var io_window_t  o_win
);

  logic [3:0]  base_nib_q;
  logic [3:0]  limit_nib_q;
  logic [15:0] base_hi_q;
  logic [15:0] limit_hi_q;
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;
  logic        rvalid_q;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire hit_base_lo  = (i_addr == `IOF_OFF_BASE_LO);
  wire hit_limit_lo = (i_addr == `IOF_OFF_LIMIT_LO);
  wire hit_base_h0  = (i_addr == `IOF_OFF_BASE_HI);
  wire hit_base_h1  = (i_addr == (`IOF_OFF_BASE_HI + 8'h01));
  wire hit_limit_h0 = (i_addr == `IOF_OFF_LIMIT_HI);
  wire hit_limit_h1 = (i_addr == (`IOF_OFF_LIMIT_HI + 8'h01));

  // writable fields; the low nibbles of the low bytes hold no storage
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      base_nib_q  <= `IOF_RST_NIBBLE;
      limit_nib_q <= `IOF_RST_NIBBLE;
      base_hi_q   <= `IOF_RST_UPPER;
      limit_hi_q  <= `IOF_RST_UPPER;
    end
    else if (i_wr)
    begin
      if (hit_base_lo)  base_nib_q        <= i_wdata[7:4];
      if (hit_limit_lo) limit_nib_q       <= i_wdata[7:4];
      if (hit_base_h0)  base_hi_q[7:0]    <= i_wdata;
      if (hit_base_h1)  base_hi_q[15:8]   <= i_wdata;
      if (hit_limit_h0) limit_hi_q[7:0]   <= i_wdata;
      if (hit_limit_h1) limit_hi_q[15:8]  <= i_wdata;
    end
  end

  // read mux; bytes outside this block read as zero
  always_comb
  begin
    if (hit_base_lo)       rdata_d = {base_nib_q, `IOF_RO_NIBBLE};
    else if (hit_limit_lo) rdata_d = {limit_nib_q, `IOF_RO_NIBBLE};
    else if (hit_base_h0)  rdata_d = base_hi_q[7:0];
    else if (hit_base_h1)  rdata_d = base_hi_q[15:8];
    else if (hit_limit_h0) rdata_d = limit_hi_q[7:0];
    else if (hit_limit_h1) rdata_d = limit_hi_q[15:8];
    else                   rdata_d = 8'h00;
  end

  // read answer one cycle after the strobe
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= i_rd ? rdata_d : rdata_q;
      rvalid_q <= i_rd;
    end
  end

  assign o_rdata  = rdata_q;
  assign o_rvalid = rvalid_q;
  // 4kb granularity: low twelve bits are implied, never stored
  assign o_win = '{base:  {base_hi_q, base_nib_q, `IOF_BASE_FILL},
                   limit: {limit_hi_q, limit_nib_q, `IOF_LIMIT_FILL}};

endmodule
`default_nettype wire

// *** test/pci_initiator_model.sv ***
// behavioural pci initiator that places one address phase per request
`timescale 1ns/1ns
`default_nettype none
module pci_initiator_model
(
  // bus clock
  input  wire logic        i_clk,
  // address phase toward the decoder
  output var  logic        o_valid,
  output var  logic        o_is_io,
  output var  logic [31:0] o_addr
);
  // idle until the bench asks for a phase
  initial
  begin
    o_valid = 1'b0;
    o_is_io = 1'b0;
    o_addr  = 32'h0000_0000;
  end
  // one phase; afterwards stale lines show the inverse so no old value lingers
  task automatic issue(input logic io, input logic [31:0] a);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_is_io = io;
    o_addr  = a;
    @(negedge i_clk);
    o_valid = 1'b0;
    o_is_io = ~io;
    o_addr  = ~a;
  endtask
endmodule
`default_nettype wire

// *** test/test_io_fwd_decoder.sv ***
// self-checking bench for the i/o forwarding decoder
`timescale 1ns/1ns
`default_nettype none
module test_io_fwd_decoder;
  import io_fwd_pkg::*;
  logic        clk, rst, wr, rd, rv, io_en, me, isa, mh;
  logic        pv, pio, sv, sio, pdv, pcl, sdv, scl;
  logic [7:0]  ca, cd, rdat;
  logic [31:0] pa, sa, pfa, sfa;
  route_t      prt, srt;
  logic [15:0] bh, lh;
  logic [3:0]  b_n, l_n;
  int          n_fail = 0;
  int          n_checks = 0;
  // shadow of the window the bench has programmed
  wire  logic [31:0] wb = {bh, b_n, 12'h000};
  wire  logic [31:0] wl = {lh, l_n, 12'hfff};

  ////////////////////////////////////////////////////////////////////////
  // clock, design and the two bus initiators
  always #4 clk = ~clk;
  io_fwd_decoder u_io_fwd_decoder (
    .i_clk(clk), .i_sys_rst(rst),
    .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(ca), .i_cfg_wdata(cd),
    .o_cfg_rdata(rdat), .o_cfg_rvalid(rv),
    .i_io_en(io_en), .i_master_en(me), .i_isa_en(isa),
    .i_pri_valid(pv), .i_pri_is_io(pio), .i_pri_addr(pa),
    .o_pri_dec_valid(pdv), .o_pri_claim(pcl), .o_pri_fwd_addr(pfa),
    .i_sec_valid(sv), .i_sec_is_io(sio), .i_sec_addr(sa),
    .i_sec_mem_up_hit(mh),
    .o_sec_dec_valid(sdv), .o_sec_claim(scl), .o_sec_fwd_addr(sfa),
    .o_pri_route(prt), .o_sec_route(srt)
  );
  pci_initiator_model u_pri_init (.i_clk(clk), .o_valid(pv), .o_is_io(pio), .o_addr(pa));
  pci_initiator_model u_sec_init (.i_clk(clk), .o_valid(sv), .o_is_io(sio), .o_addr(sa));

  ////////////////////////////////////////////////////////////////////////
  // expectations worked out from the window shadow and the enables
  function automatic logic inw(input logic [31:0] a);
    return a >= wb && a <= wl;
  endfunction
  function automatic logic isa_blk(input logic [31:0] a);
    return isa && a[31:16] == 16'h0000 && a[9:8] != 2'h0;
  endfunction
  function automatic logic exp_down(input logic [31:0] a, input logic io);
    return io && io_en && inw(a) && !isa_blk(a);
  endfunction
  function automatic logic exp_up(input logic [31:0] a, input logic io);
    return me && (io ? (!inw(a) || isa_blk(a)) : mh);
  endfunction
  // boundary-heavy address picks
  function automatic logic [31:0] pick();
    case ($urandom % 6)
      0: return wb - 32'h1;
      1: return wb;
      2: return wl;
      3: return wl + 32'h1;
      4: return {bh, b_n, 12'($urandom)};
      default: return $urandom & 32'h0001_ffff;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // compare, closing report and watchdog
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish;
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration byte access
  task automatic wbyte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    ca = a;
    cd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // random window; low nibbles get random junk that must be dropped
  task automatic prog(input int hi);
    bh = 16'($urandom_range(0, hi));
    lh = 16'($urandom_range(0, hi));
    b_n = 4'($urandom);
    l_n = 4'($urandom);
    wbyte(8'h1c, {b_n, 4'($urandom)});
    wbyte(8'h1d, {l_n, 4'($urandom)});
    wbyte(8'h30, bh[7:0]);
    wbyte(8'h31, bh[15:8]);
    wbyte(8'h32, lh[7:0]);
    wbyte(8'h33, lh[15:8]);
  endtask
  // read every live byte plus one unmapped offset
  task automatic read_all;
    logic [7:0] ex [7];
    logic [7:0] ofs [7];
    ex = '{{b_n, 4'h1}, {l_n, 4'h1}, bh[7:0], bh[15:8], lh[7:0], lh[15:8], 8'h00};
    ofs = '{8'h1c, 8'h1d, 8'h30, 8'h31, 8'h32, 8'h33, 8'h20};
    for (int i = 0; i < 7; i++)
    begin
      @(negedge clk);
      rd = 1'b1;
      ca = ofs[i];
      @(negedge clk);
      rd = 1'b0;
      chk(32'(rv), 32'h1, "read strobe");
      chk(32'(rdat), 32'(ex[i]), "config byte");
    end
    // strobe lasts one cycle, read byte stays until the next read
    @(negedge clk);
    chk(32'(rv), 32'h0, "read strobe length");
    chk(32'(rdat), 32'(ex[6]), "read data hold");
  endtask
  // one phase on each bus at once, answer checked the cycle after
  task automatic dec(input logic [31:0] a, input logic [31:0] b, input logic ia, input logic ib);
    logic d, u;
    d = exp_down(a, ia);
    u = exp_up(b, ib);
    fork
      u_pri_init.issue(ia, a);
      u_sec_init.issue(ib, b);
    join
    chk(32'(pdv & sdv), 32'h1, "decode strobe");
    chk(32'(pcl), 32'(d), "primary claim");
    chk(32'(prt), 32'(d ? ROUTE_DOWN : ROUTE_NONE), "primary route");
    chk(pfa, a, "primary address");
    chk(32'(scl), 32'(u), "secondary claim");
    chk(32'(srt), 32'(u ? ROUTE_UP : ROUTE_NONE), "secondary route");
    chk(sfa, b, "secondary address");
    @(negedge clk);
    chk(32'(pdv | sdv | pcl | scl), 32'h0, "answer length");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {clk, rst, wr, rd, io_en, me, isa, mh} = 8'h40;
    {ca, cd, bh, lh, b_n, l_n} = 56'h0;
    void'($urandom(59052));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    read_all;
    io_en = 1'b1;
    me = 1'b1;
    dec(32'h0000_0fff, 32'h0000_1000, 1'b1, 1'b1);
    dec(32'h0000_1000, 32'h0000_0000, 1'b1, 1'b1);
    isa = 1'b1;
    mh = 1'b1;
    dec(32'h0000_0100, 32'h0000_0100, 1'b1, 1'b1);
    dec(32'h0000_04ff, 32'h0000_0c00, 1'b1, 1'b1);
    dec(32'h0000_0400, 32'h0000_0ffc, 1'b0, 1'b0);
    $display("test reset window and isa done");
    io_en = 1'b0;
    me = 1'b0;
    prog(65535);
    wbyte(8'h20, 8'hff);
    read_all;
    $display("test register access done");
    for (int i = 0; i < 400; i++)
    begin
      if (i % 25 == 0)
      begin
        io_en = 1'b0;
        me = 1'b0;
        prog(2);
        isa = 1'($urandom);
      end
      io_en = ($urandom % 4) != 0;
      me = ($urandom % 4) != 0;
      mh = 1'($urandom);
      dec(pick(), pick(), ($urandom % 4) != 0, ($urandom % 4) != 0);
    end
    $display("test random decode done");
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    {bh, lh, b_n, l_n} = 40'h0;
    read_all;
    $display("test second reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
